//--- rtl/hpdpc_cfg.sv
// hpdpc_cfg: port-disable masks, self-powered current budget and the port
// renumbering they imply, plus the gate on host port enables.
// assumes synchronous inputs, one 20 MHz clock, and a register master that
// issues one-cycle strobes and never expects a wait.
//
// Contract
// RQ1: mask bit clear means port available, set means port disabled.
// RQ2: host can never enable a port the active mask disables.
// RQ3: report count of enabled ports and renumber active ports contiguously.
// RQ4: mask bits 1..3 govern ports 1..3; bit 0 and upper bits do nothing.
// RQ5: self-powered operation takes disabled ports from the self-powered mask.
// RQ6: bus-powered operation takes disabled ports from the bus-powered mask.
// RQ7: internal default option takes disabled ports from the two strap pins.
// RQ8: configuring party keeps bit 1 clear so the card reader enumerates.
// RQ9: self-powered budget reported to host at two milliamperes per count.
// RQ10: configuring party adds embedded peripheral draw when it declares zero.
// RQ11: configuring party keeps self-powered budget at or below 100 mA.
// RQ12: compound flag is reported; attached ports are declared non-removable.
// RQ13: reserved mask bits ignore writes and read as zero.
`timescale 1ns/1ps

module hpdpc_cfg
  import hpdpc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  input  wire logic       self_powered,
  input  wire logic       use_internal_default,
  input  wire logic [1:0] port_off_strap_pins,
  input  wire logic [3:1] host_port_en_logical,
  output logic      [3:1] port_active,
  output logic      [1:0] reported_port_count,
  output logic      [5:0] logical_port_num,
  output logic      [3:1] phys_port_en,
  output logic      [8:0] current_budget_ma,
  output logic            compound_device,
  output logic      [3:1] nonremovable_logical
);

  // ==========================================================================
  // decoding helpers
  function automatic logic [3:1] strap_decode(input logic [1:0] code);
    case (code)
      2'h0:    strap_decode = HPDPC_STRAP_00;
      2'h1:    strap_decode = HPDPC_STRAP_01;
      2'h2:    strap_decode = HPDPC_STRAP_10;
      default: strap_decode = HPDPC_STRAP_11;
    endcase
  endfunction : strap_decode

  // logical number of each physical port, 2 bits per port, 0 when hidden
  function automatic logic [5:0] renumber(input logic [3:1] act);
    logic [1:0] n;
    n = 2'h0;
    renumber = 6'h00;
    for (int p = 1; p <= 3; p++) begin
      if (act[p]) begin
        n = n + 2'h1;
        renumber[2*(p-1) +: 2] = n;
      end
    end
  endfunction : renumber

  function automatic logic [1:0] count_on(input logic [3:1] act);
    count_on = {1'b0, act[1]} + {1'b0, act[2]} + {1'b0, act[3]};
  endfunction : count_on

  hpdpc_state_t st;
  hpdpc_state_t next_st;
  logic [3:1]   sel_off;

  // ==========================================================================
  // disabled-port selection
  always_comb begin
    if (use_internal_default) begin
      sel_off = strap_decode(port_off_strap_pins);  // RQ7
    end else if (self_powered) begin
      sel_off = st.sp_mask[3:1];  // RQ5 RQ4
    end else begin
      sel_off = st.bp_mask[3:1];  // RQ6 RQ4
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    next_st = st;
    if (wr_en) begin
      case (addr)
        HPDPC_SP_MASK_OFS: next_st.sp_mask = wr_data & HPDPC_MASK_IMPL;  // RQ13
        HPDPC_BP_MASK_OFS: next_st.bp_mask = wr_data & HPDPC_MASK_IMPL;  // RQ13
        HPDPC_BUDGET_OFS:  next_st.budget  = wr_data;
        HPDPC_CTRL_OFS:    next_st.ctrl    = wr_data & HPDPC_CTRL_IMPL;
        default:           next_st.ctrl    = st.ctrl;
      endcase
    end
    next_st.rd_data = 8'h00;
    if (rd_en) begin
      case (addr)
        HPDPC_SP_MASK_OFS: next_st.rd_data = st.sp_mask;
        HPDPC_BP_MASK_OFS: next_st.rd_data = st.bp_mask;
        HPDPC_BUDGET_OFS:  next_st.rd_data = st.budget;
        HPDPC_CTRL_OFS:    next_st.rd_data = st.ctrl;
        HPDPC_STATUS_OFS:  next_st.rd_data = {2'h0, st.count, st.active, 1'b0};
        default:           next_st.rd_data = 8'h00;
      endcase
    end
    // a clear bit means available, so the active set is the complement
    next_st.active = ~sel_off;  // RQ1
    next_st.count  = count_on(~sel_off);  // RQ3
    next_st.log_num = renumber(~sel_off);  // RQ3
    // host asks by logical number; a hidden port has no number to ask by
    for (int p = 1; p <= 3; p++) begin
      next_st.phys_en[p] = 1'b0;
      next_st.nonrem_log[p] = 1'b0;
    end
    for (int p = 1; p <= 3; p++) begin
      if (!sel_off[p]) begin
        next_st.phys_en[p] =
          host_port_en_logical[next_st.log_num[2*(p-1) +: 2]];  // RQ2
        next_st.nonrem_log[next_st.log_num[2*(p-1) +: 2]] = st.ctrl[p];  // RQ12
      end
    end
    next_st.budget_ma = {st.budget, 1'b0};  // RQ9
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st            <= '0;
      st.sp_mask    <= HPDPC_SP_MASK_RST;
      st.bp_mask    <= HPDPC_BP_MASK_RST;
      st.budget     <= HPDPC_BUDGET_RST;
      st.ctrl       <= HPDPC_CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data              = st.rd_data;
  assign port_active          = st.active;
  assign reported_port_count  = st.count;
  assign logical_port_num     = st.log_num;
  assign phys_port_en         = st.phys_en;
  assign current_budget_ma    = st.budget_ma;
  assign compound_device      = st.ctrl[HPDPC_CTRL_COMPOUND];  // RQ12
  assign nonremovable_logical = st.nonrem_log;

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // sampled reset in the antecedent keeps the release edge from judging reset values
  property p_active_is_clear_bits;
    rst_n |=> port_active == ~$past(sel_off);
  endproperty
  a_active_is_clear_bits: assert property (p_active_is_clear_bits) // RQ1
    else $error("active ports do not follow the selected mask");

  property p_no_disabled_enable;
    (phys_port_en & ~port_active) == 3'h0;
  endproperty
  a_no_disabled_enable: assert property (p_no_disabled_enable) // RQ2
    else $error("a disabled port was enabled");

  property p_count_matches;
    ##1 reported_port_count == 2'($countones(port_active));
  endproperty
  a_count_matches: assert property (p_count_matches) // RQ3
    else $error("reported port count wrong");

  property p_mask_store;
    wr_en && addr == HPDPC_SP_MASK_OFS |=> st.sp_mask == ($past(wr_data) & 8'h000e);
  endproperty
  a_mask_store: assert property (p_mask_store) // RQ4
    else $error("self-powered mask stored wrong bits");

  property p_sp_select;
    rst_n && self_powered && !use_internal_default
      |=> port_active == ~$past(st.sp_mask[3:1]);
  endproperty
  a_sp_select: assert property (p_sp_select) // RQ5
    else $error("self-powered mask not in force");

  property p_bp_select;
    rst_n && !self_powered && !use_internal_default
      |=> port_active == ~$past(st.bp_mask[3:1]);
  endproperty
  a_bp_select: assert property (p_bp_select) // RQ6
    else $error("bus-powered mask not in force");

  property p_strap_select;
    rst_n && use_internal_default && port_off_strap_pins == 2'h1 |=> port_active == 3'h3;
  endproperty
  a_strap_select: assert property (p_strap_select) // RQ7
    else $error("strap pins not in force");

  property p_budget_scale;
    ##1 current_budget_ma == {$past(st.budget), 1'b0};
  endproperty
  a_budget_scale: assert property (p_budget_scale) // RQ9
    else $error("budget not scaled by two");

  property p_compound;
    wr_en && addr == HPDPC_CTRL_OFS |=> compound_device == $past(wr_data[0]);
  endproperty
  a_compound: assert property (p_compound) // RQ12
    else $error("compound flag not reported");

  property p_rsvd_read;
    rd_en && (addr == HPDPC_SP_MASK_OFS || addr == HPDPC_BP_MASK_OFS)
      |=> (rd_data & ~8'h000e) == 8'h00;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) // RQ13
    else $error("reserved mask bit read nonzero");

endmodule : hpdpc_cfg

//--- rtl/hpdpc_pkg.sv
// hpdpc_pkg: offsets, field layouts, reset values and state type of the
// hub port-disable and power configuration bank.
// assumes one 20 MHz core clock and an 8-bit register port.
package hpdpc_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] HPDPC_SP_MASK_OFS  = 8'h00e8;
  localparam logic [7:0] HPDPC_BP_MASK_OFS  = 8'h00e9;
  localparam logic [7:0] HPDPC_BUDGET_OFS   = 8'h00ea;
  localparam logic [7:0] HPDPC_CTRL_OFS     = 8'h00f0;
  localparam logic [7:0] HPDPC_STATUS_OFS   = 8'h00f1;

  // ==========================================================================
  // field layouts
  localparam logic [7:0] HPDPC_MASK_IMPL    = 8'h000e;  // bits 3:1 govern ports 3:1
  localparam logic [7:0] HPDPC_CTRL_IMPL    = 8'h000f;  // bit 0 compound, 3:1 non-removable
  localparam int         HPDPC_CTRL_COMPOUND = 0;
  localparam int         HPDPC_STAT_COUNT_LSB = 4;

  // ==========================================================================
  // reset values
  localparam logic [7:0] HPDPC_SP_MASK_RST  = 8'h0000;
  localparam logic [7:0] HPDPC_BP_MASK_RST  = 8'h0000;
  localparam logic [7:0] HPDPC_BUDGET_RST   = 8'h0000;
  localparam logic [7:0] HPDPC_CTRL_RST     = 8'h0000;

  // ==========================================================================
  // strap codes for the internal default option, as disabled-port masks
  localparam logic [3:1] HPDPC_STRAP_00     = 3'h0;  // all ports on
  localparam logic [3:1] HPDPC_STRAP_01     = 3'h4;  // port 3 off
  localparam logic [3:1] HPDPC_STRAP_10     = 3'h6;  // ports 3 and 2 off
  localparam logic [3:1] HPDPC_STRAP_11     = 3'h2;  // port 2 off

  typedef struct packed {
    logic [7:0] sp_mask;
    logic [7:0] bp_mask;
    logic [7:0] budget;
    logic [7:0] ctrl;
    logic [7:0] rd_data;
    logic [3:1] active;
    logic [1:0] count;
    logic [5:0] log_num;
    logic [3:1] phys_en;
    logic [8:0] budget_ma;
    logic [3:1] nonrem_log;
  } hpdpc_state_t;

endpackage : hpdpc_pkg

//--- test/hpdpc_host_model.sv
// hpdpc_host_model: upstream host that enumerates the hub and enables ports.
// assumes the hub's port count is registered on ref_clk.
`timescale 1ns/1ps

module hpdpc_host_model
  import hpdpc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       tamper,
  input  wire logic [1:0] reported_port_count,
  output logic      [3:1] host_port_en_logical
);
  // ==========================================================================
  // enable policy
  // tamper makes the host reach for logical numbers the hub never reported
  always_ff @(posedge ref_clk) begin
    if (!rst_n) host_port_en_logical <= 3'h0;
    else if (tamper) host_port_en_logical <= 3'h7;
    else host_port_en_logical <= 3'((4'h1 << reported_port_count) - 4'h1);
  end
endmodule : hpdpc_host_model

//--- test/tb_hpdpc_cfg.sv
// tb_hpdpc_cfg: random mask, strap and budget configurations, checked at ports.
// assumes the design answers reads one cycle later and never stalls.
`timescale 1ns/1ps

module tb_hpdpc_cfg
  import hpdpc_pkg::*;
;
  logic       ref_clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, sel = 0, useint = 0, tamper = 0;
  logic [7:0] addr = 0, wr_data = 0, rd_data, sp, bp, b, c;
  logic [1:0] strap = 0, cnt, reported_port_count;
  logic [3:1] hen, act, en, nr, port_active, phys_port_en, nonremovable_logical;
  logic [5:0] lnum, logical_port_num;
  logic [8:0] current_budget_ma;
  logic       compound_device, rd_v = 0;
  logic [7:0] q[$];
  int         err_total = 0, num_checks = 0, seed = 32'h933b_7c34;

  always #25 ref_clk = ~ref_clk;

  hpdpc_cfg hpdpc_cfg_inst (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .self_powered(sel),
    .use_internal_default(useint), .port_off_strap_pins(strap),
    .host_port_en_logical(hen), .port_active(port_active),
    .reported_port_count(reported_port_count), .logical_port_num(logical_port_num),
    .phys_port_en(phys_port_en), .current_budget_ma(current_budget_ma),
    .compound_device(compound_device), .nonremovable_logical(nonremovable_logical));
  hpdpc_host_model hpdpc_host_model_inst (.ref_clk(ref_clk), .rst_n(rst_n), .tamper(tamper),
    .reported_port_count(reported_port_count), .host_port_en_logical(hen));

  task automatic end_sim;
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a; wr_data <= d; wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a; rd_en <= 1'b1; q.push_back(e);
    @(posedge ref_clk);
    rd_en <= 1'b0;
  endtask : rd

  // ==========================================================================
  // read watcher: data stands only in the cycle after the strobe, else zero
  always @(posedge ref_clk) begin
    // state is unknown before the first reset edge, so reads are judged only after it
    if (rst_n) begin
      if (rd_v) chk(rd_data, q.pop_front());
      else chk(rd_data, 8'h00);
    end
    rd_v <= rd_en;
  end

  initial begin
    #(50 * 20000);
    err_total++;
    end_sim();
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      @(posedge ref_clk);
      sel <= i[0]; strap <= i[2:1]; useint <= i[3]; tamper <= i[1] ^ i[0];
      sp = 8'($random(seed)) & 8'hfd;
      bp = 8'($random(seed)) & 8'hfd;
      b = 8'($unsigned($random(seed)) % 51);
      c = 8'($random(seed));
      wr(HPDPC_SP_MASK_OFS, sp);
      wr(HPDPC_BP_MASK_OFS, bp);
      wr(HPDPC_BUDGET_OFS, b);
      wr(HPDPC_CTRL_OFS, c);
      wr(HPDPC_STATUS_OFS, 8'hff);
      rd(HPDPC_SP_MASK_OFS, sp & 8'h0e);
      rd(HPDPC_BP_MASK_OFS, bp & 8'h0e);
      rd(HPDPC_BUDGET_OFS, b);
      rd(HPDPC_CTRL_OFS, c & 8'h0f);
      rd(8'h00, 8'h00);
      repeat (5) @(posedge ref_clk);
      if (useint) begin
        case (strap)
          2'd0: act = ~HPDPC_STRAP_00;
          2'd1: act = ~HPDPC_STRAP_01;
          2'd2: act = ~HPDPC_STRAP_10;
          default: act = ~HPDPC_STRAP_11;
        endcase
      end else act = sel ? ~sp[3:1] : ~bp[3:1];
      cnt = 0; lnum = 0; en = 0;
      nr = 0;
      // the host enables every logical number it was given, or all three when tampering,
      // so each active port must come up enabled and no hidden one ever may
      for (int p = 1; p <= 3; p++) begin
        if (act[p]) begin
          cnt++;
          lnum[2*(p-1)+:2] = cnt;
          en[p] = 1'b1;
          nr[cnt] = c[p];
        end
      end
      @(negedge ref_clk);
      chk(port_active, act);
      chk(reported_port_count, cnt);
      chk(logical_port_num, lnum);
      chk(phys_port_en, en);
      chk(current_budget_ma, {b, 1'b0});
      chk(compound_device, c[0]);
      chk(nonremovable_logical, nr);
      rd(HPDPC_STATUS_OFS, {2'b00, cnt, act, 1'b0});
    end
    repeat (3) @(posedge ref_clk);
    end_sim();
  end
endmodule : tb_hpdpc_cfg
